//--- logic/fac_fault_address_capture.sv
// Level-1 data and level-2 fault address capture registers
`include "fac_cfg.svh"

module fac_fault_address_capture (
    // Clock and hard power-on reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    // Error report from the detectors
    input  wire logic                 err_valid_i,
    input  wire logic                 err_l1_raw_ue_i,
    input  wire fac_pkg::fac_prio_type l1_record_priority_i,
    input  wire fac_pkg::fac_prio_type l2_record_priority_i,
    input  wire logic                 err_way_i,
    input  wire logic [2:0]           virtual_index_bits_i,
    input  wire logic [42:6]          line_physical_address_i,
    input  wire logic [42:3]          l2_physical_address_i,
    input  wire logic [7:0]           l2_syndrome_i,
    // Alternate-space access
    input  wire logic                 asi_rd_i,
    input  wire logic                 asi_wr_i,
    input  wire logic [7:0]           asi_va_i,
    output logic      [63:0]          asi_rdata_o,
    output logic                      asi_ack_o,
    // Register contents
    output logic      [63:0]          l1_data_fault_address_o,
    output logic      [63:0]          l2_fault_address_o
);

    // Reset release copies
    logic                  rst_meta_q;
    logic                  rst_sync_q;

    // Incoming error priority and capture words
    fac_pkg::fac_prio_type l1_prio;
    fac_pkg::fac_reg_type  l1_capture;
    fac_pkg::fac_reg_type  l2_capture;

    // Read decode
    logic                  rd_l1_hit;
    logic                  rd_l2_hit;

    // Read data and acknowledge
    logic [63:0]           rdata_q;
    logic [63:0]           rdata_d;
    logic                  ack_q;
    logic                  ack_d;

    // Decode of the register addressed by a virtual address
    function automatic logic hit_reg(
        input logic [7:0]           va,
        input fac_pkg::fac_sel_type sel
    );
        if (sel == fac_pkg::FAC_SEL_L1) begin
            return va == `FAC_L1_VA;
        end
        return va == `FAC_L2_VA;
    endfunction : hit_reg

    // Stored tag loses to the incoming priority
    function automatic logic outranks(
        input fac_pkg::fac_prio_type stored,
        input fac_pkg::fac_prio_type incoming
    );
        return stored < incoming;
    endfunction : outranks

    // Level-1 capture word
    function automatic fac_pkg::fac_reg_type pack_l1(
        input fac_pkg::fac_prio_type prio,
        input logic                  way,
        input logic [2:0]            vidx,
        input logic [42:6]           pa
    );
        fac_pkg::fac_reg_type word;
        // Fields not named below read as zero
        word = `FAC_RESET_VALUE;
        word[`FAC_TAG_HI:`FAC_TAG_LO] = prio;
        word[`FAC_WAY_BIT] = way;
        word[`FAC_VIDX_HI:`FAC_VIDX_LO] = vidx;
        word[`FAC_PA_HI:`FAC_PA_LO] = pa;
        return word;
    endfunction : pack_l1

    // Level-2 capture word
    function automatic fac_pkg::fac_reg_type pack_l2(
        input fac_pkg::fac_prio_type prio,
        input logic [7:0]            syndrome,
        input logic [42:3]           pa
    );
        fac_pkg::fac_reg_type word;
        // Fields not named below read as zero
        word = `FAC_RESET_VALUE;
        word[`FAC_TAG_HI:`FAC_TAG_LO] = prio;
        word[`FAC_SYN_HI:`FAC_SYN_LO] = syndrome;
        word[`FAC_PA_HI:`FAC_L2_PA_LO] = pa;
        return word;
    endfunction : pack_l2

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Raw level-1 data uncorrectable error uses its fixed priority
    assign l1_prio = err_l1_raw_ue_i ? `FAC_PRIO_L1_RAW_UE
                                     : l1_record_priority_i;

    // Capture words from the detector inputs
    assign l1_capture = pack_l1(l1_prio, err_way_i, virtual_index_bits_i,
                                line_physical_address_i);
    assign l2_capture = pack_l2(l2_record_priority_i, l2_syndrome_i,
                                l2_physical_address_i);

    // One capture slot per register, level-1 first
    for (genvar g = 0; g < 2; g++) begin : g_slot
        // Slot state and controls
        fac_pkg::fac_reg_type  slot_q;
        fac_pkg::fac_reg_type  slot_d;
        fac_pkg::fac_reg_type  word;
        fac_pkg::fac_prio_type prio;
        fac_pkg::fac_sel_type  sel;
        logic                  clear;
        logic                  record;

        // Register select, capture word and priority of this slot
        assign sel    = (g == 0) ? fac_pkg::FAC_SEL_L1 : fac_pkg::FAC_SEL_L2;
        assign word   = (g == 0) ? l1_capture : l2_capture;
        assign prio   = (g == 0) ? l1_prio : l2_record_priority_i;
        assign clear  = asi_wr_i && hit_reg(asi_va_i, sel);
        assign record = err_valid_i &&
                        outranks(slot_q[`FAC_TAG_HI:`FAC_TAG_LO], prio);

        // A write wins over an error in the same cycle
        always_comb begin
            slot_d = slot_q;
            if (clear) begin
                slot_d = `FAC_RESET_VALUE;
            end else if (record) begin
                slot_d = word;
            end
        end

        // The hard power-on reset clears a slot, as does an alternate-space write through slot_d
        always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                slot_q <= `FAC_RESET_VALUE;
            end else begin
                slot_q <= slot_d;
            end
        end
    end

    // Read decode per register
    assign rd_l1_hit = asi_rd_i && hit_reg(asi_va_i, fac_pkg::FAC_SEL_L1);
    assign rd_l2_hit = asi_rd_i && hit_reg(asi_va_i, fac_pkg::FAC_SEL_L2);

    // Read data, zero for a write or an unmapped address
    always_comb begin
        rdata_d = `FAC_RESET_VALUE;
        if (rd_l1_hit) begin
            rdata_d = g_slot[0].slot_q;
        end else if (rd_l2_hit) begin
            rdata_d = g_slot[1].slot_q;
        end
    end

    // Read data register
    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= `FAC_RESET_VALUE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Acknowledge one cycle after any access
    always_comb begin
        ack_d = asi_rd_i | asi_wr_i;
    end

    // Acknowledge register
    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // Access answer
    assign asi_rdata_o             = rdata_q;
    assign asi_ack_o               = ack_q;

    // Register contents straight from the slots
    assign l1_data_fault_address_o = g_slot[0].slot_q;
    assign l2_fault_address_o      = g_slot[1].slot_q;

endmodule : fac_fault_address_capture

//--- logic/fac_cfg.svh
// Offsets, field positions, reset values and priority constants
`ifndef FAC_CFG_SVH
`define FAC_CFG_SVH
`define FAC_L1_VA          8'h00
`define FAC_L2_VA          8'h08
`define FAC_TAG_HI         63
`define FAC_TAG_LO         56
`define FAC_WAY_BIT        55
`define FAC_SYN_HI         55
`define FAC_SYN_LO         48
`define FAC_VIDX_HI        50
`define FAC_VIDX_LO        48
`define FAC_PA_HI          42
`define FAC_PA_LO          6
`define FAC_L2_PA_LO       3
`define FAC_RESET_VALUE    64'h0000000000000000
`define FAC_PRIO_L1_RAW_UE 8'h80
`endif

//--- logic/fac_pkg.sv
// Types shared by the fault address capture logic
package fac_pkg;
    typedef logic [7:0]  fac_prio_type;
    typedef logic [63:0] fac_reg_type;
    typedef enum logic [0:0] {
        FAC_SEL_L1 = 1'b0,
        FAC_SEL_L2 = 1'b1
    } fac_sel_type;
endpackage : fac_pkg

//--- dv/fac_chk.sv
// Checker for the fault address capture registers
module fac_chk (
    input wire logic                  clk_sys_i, resetn_i, err_valid_i,
    input wire logic                  err_l1_raw_ue_i, asi_rd_i, asi_wr_i,
    input wire logic                  asi_ack_o,
    input wire fac_pkg::fac_prio_type l1_record_priority_i,
    input wire fac_pkg::fac_prio_type l2_record_priority_i,
    input wire logic [7:0]            asi_va_i,
    input wire logic [63:0]           l1_data_fault_address_o,
    input wire logic [63:0]           l2_fault_address_o
);
    logic [63:0] a1, a2;
    logic [7:0]  p1, p2;
    logic        e, w1, w2;
    assign a1 = l1_data_fault_address_o;
    assign a2 = l2_fault_address_o;
    assign e  = err_valid_i;
    assign p2 = l2_record_priority_i;
    assign p1 = err_l1_raw_ue_i ? 8'h80 : l1_record_priority_i;
    assign w1 = asi_wr_i && asi_va_i == 8'h00;
    assign w2 = asi_wr_i && asi_va_i == 8'h08;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_L1_REC: assert property (e && p1 > a1[63:56] && !w1 |=>
        a1[63:56] == $past(p1)) else $error("l1 tag not loaded");
    AST_L1_KEEP: assert property (e && p1 <= a1[63:56] && !w1 |=>
        $stable(a1)) else $error("l1 changed on lower priority");
    AST_L1_CLR: assert property (w1 |=> a1 == 64'h0)
        else $error("l1 not cleared by write");
    AST_L1_RSV: assert property (
        {a1[54:51], a1[47:43], a1[5:0]} == 15'h0)
        else $error("l1 reserved bits set");
    AST_L2_REC: assert property (e && p2 > a2[63:56] && !w2 |=>
        a2[63:56] == $past(p2)) else $error("l2 tag not loaded");
    AST_L2_KEEP: assert property (e && p2 <= a2[63:56] && !w2 |=>
        $stable(a2)) else $error("l2 changed on lower priority");
    AST_L2_CLR: assert property (w2 |=> a2 == 64'h0)
        else $error("l2 not cleared by write");
    AST_ACK: assert property (asi_ack_o == $past(asi_rd_i || asi_wr_i))
        else $error("ack not one cycle after access");
    cover property (e && p1 > a1[63:56]);
    cover property (w1);
    cover property (w2);
    cover property (e && p2 > a2[63:56]);
endmodule : fac_chk

bind fac_fault_address_capture fac_chk u_chk (.*);

//--- dv/fac_fault_address_capture_bench.sv
// Self-checking bench for the fault address capture registers
module fac_fault_address_capture_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        ev = 1'b0;
    logic        raw = 1'b0;
    logic        way = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  p1 = 8'h00;
    logic [7:0]  p2 = 8'h00;
    logic [7:0]  va = 8'h00;
    logic [7:0]  syn = 8'h00;
    logic [2:0]  vi = 3'h0;
    logic [42:6] pa = '0;
    logic [42:3] pb = '0;
    logic [63:0] rdat;
    logic [63:0] o1;
    logic [63:0] o2;
    logic [63:0] x1 = 64'h0;
    logic [63:0] x2 = 64'h0;
    logic        ack;
    int          fail_count = 0;
    int          checked = 0;
    // Rows: raw flag, level-1 priority, expected level-1 and level-2 tags
    logic [24:0] rows [5] = '{25'h0404080, 25'h03040F0, 25'h04040F0,
                              25'h11080F0, 25'h0FFFFF0};
    fac_fault_address_capture u_dut (
        .clk_sys_i               (clk_sys_i),
        .resetn_i                (resetn_i),
        .err_valid_i             (ev),
        .err_l1_raw_ue_i         (raw),
        .l1_record_priority_i    (p1),
        .l2_record_priority_i    (p2),
        .err_way_i               (way),
        .virtual_index_bits_i    (vi),
        .line_physical_address_i (pa),
        .l2_physical_address_i   (pb),
        .l2_syndrome_i           (syn),
        .asi_rd_i                (rd),
        .asi_wr_i                (wr),
        .asi_va_i                (va),
        .asi_rdata_o             (rdat),
        .asi_ack_o               (ack),
        .l1_data_fault_address_o (o1),
        .l2_fault_address_o      (o2)
    );
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string n, input logic [63:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic err(input logic [8:0] r, input logic [2:0] i);
        logic [36:0] a;
        logic [7:0]  q;
        logic [7:0]  t;
        a = {i, 34'h155555555};
        q = r[7:0] ^ 8'hC0;
        t = r[8] ? 8'h80 : r[7:0];
        @(posedge clk_sys_i);
        ev <= 1'b1;
        raw <= r[8];
        p1 <= r[7:0];
        p2 <= q;
        way <= i[0];
        vi <= ~i;
        pa <= a;
        pb <= {a, 3'h5};
        syn <= {i, 5'h0A};
        if (t > x1[63:56]) begin
            x1 = {t, i[0], 4'h0, ~i, 5'h0, a, 6'h0};
        end
        if (q > x2[63:56]) begin
            x2 = {q, i, 5'h0A, 5'h0, a, 3'h5, 3'h0};
        end
        @(posedge clk_sys_i);
        ev <= 1'b0;
        #1 chk("l1", o1, x1);
        chk("l2", o2, x2);
    endtask : err
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [63:0] e);
        @(posedge clk_sys_i);
        wr <= w;
        rd <= !w;
        va <= a;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 chk("ack", {63'h0, ack}, 64'h1);
        chk("rdata", rdat, e);
    endtask : acc
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        foreach (rows[i]) begin
            err(rows[i][24:16], 3'(i));
            chk("t1", {56'h0, o1[63:56]}, {56'h0, rows[i][15:8]});
            chk("t2", {56'h0, o2[63:56]}, {56'h0, rows[i][7:0]});
        end
        acc(1'b0, 8'h00, x1);
        acc(1'b0, 8'h08, x2);
        acc(1'b0, 8'h10, 64'h0);
        acc(1'b1, 8'h00, 64'h0);
        chk("l1 clr", o1, 64'h0);
        chk("l2 kept", o2, x2);
        acc(1'b1, 8'h08, 64'h0);
        chk("l2 clr", o2, 64'h0);
        x1 = 64'h0;
        x2 = 64'h0;
        err(9'h020, 3'h6);
        // Write and error in one cycle: the write wins for level-1
        @(posedge clk_sys_i);
        ev <= 1'b1;
        raw <= 1'b1;
        p2 <= 8'hF0;
        wr <= 1'b1;
        va <= 8'h00;
        x2 = {8'hF0, x2[55:0]};
        @(posedge clk_sys_i);
        ev <= 1'b0;
        raw <= 1'b0;
        wr <= 1'b0;
        #1 chk("l1 wr err", o1, 64'h0);
        chk("l2 wr err", o2, x2);
        // Hard reset in mid-run, then release and capture again
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        #1 chk("l1 por", o1, 64'h0);
        chk("l2 por", o2, 64'h0);
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (2) begin
            @(posedge clk_sys_i);
            #1 chk("ack rel", {63'h0, ack}, 64'h0);
            chk("l2 rel", o2, 64'h0);
        end
        @(posedge clk_sys_i);
        x1 = 64'h0;
        x2 = 64'h0;
        err(9'h050, 3'h2);
        wrap_up;
    end
endmodule : fac_fault_address_capture_bench
